// ===== pkg/route_cfg_if.sv
// Route settings passed from the register file to the multiplexer
`timescale 1ns/1ps
interface route_cfg_if;
  route_pkg::spi_route_t spiRoute;
  route_pkg::tca_route_t tcaRoute;
  route_pkg::tcb_route_t tcbRoute;
  modport src (output spiRoute, output tcaRoute, output tcbRoute);
  modport sink (input spiRoute, input tcaRoute, input tcbRoute);
endinterface

// ===== pkg/route_params.svh
// Constants for the peripheral pin route selector
`ifndef ROUTE_PARAMS_SVH
`define ROUTE_PARAMS_SVH
`define RT_GROUPS 6
`define RT_GROUP_PINS 8
`define RT_PINS 48
`define RT_TCA_OUTS 6
`define RT_TCB_OUTS 4
`define RT_SPI_SIGS 4
`define RT_SPI_IDX 8'h03
`define RT_TCA_IDX 8'h04
`define RT_TCB_IDX 8'h05
`define RT_SPI_RESET 2'h0
`define RT_TCA_RESET 3'h0
`define RT_TCB_RESET 4'h0
`define RT_TCA_LAST 3'h5
`define RT_TCA_MASK 48'h00000000003F
`define RT_PIN_A4 6'h04
`define RT_PIN_C0 6'h10
`define RT_PIN_E0 6'h20
`define RT_TYPE_B_TIMER0_ROUTE_DEF 6'h02
`define RT_TYPE_B_TIMER0_ROUTE_ALT 6'h2C
`define RT_TYPE_B_TIMER1_ROUTE_DEF 6'h03
`define RT_TYPE_B_TIMER1_ROUTE_ALT 6'h2D
`define RT_TYPE_B_TIMER2_ROUTE_DEF 6'h10
`define RT_TYPE_B_TIMER2_ROUTE_ALT 6'h0C
`define RT_TYPE_B_TIMER3_ROUTE_DEF 6'h0D
`define RT_TYPE_B_TIMER3_ROUTE_ALT 6'h11
`define RT_RESP_OKAY 2'h0
`define RT_RESP_SLVERR 2'h2
`endif

// ===== pkg/route_pkg.sv
// Types for the peripheral pin route selector
package route_pkg;
  typedef enum logic [1:0] {
    SPI_ON_A_HIGH = 2'h0,
    SPI_ON_C_LOW = 2'h1,
    SPI_ON_E_LOW = 2'h2,
    SPI_DETACHED = 2'h3
  } spi_route_t;
  typedef enum logic [1:0] {
    REG_NONE = 2'h0,
    REG_SPI = 2'h1,
    REG_TCA = 2'h2,
    REG_TCB = 2'h3
  } reg_sel_t;
  typedef logic [2:0] tca_route_t;
  typedef logic [3:0] tcb_route_t;
  typedef logic [5:0] pin_idx_t;
endpackage

// ===== rtl/route_mux.sv
// Combinational override multiplexer from peripherals onto pin groups
`timescale 1ns/1ps
`include "route_params.svh"
module route_mux (
  route_cfg_if.sink cfg,
  input wire logic [`RT_SPI_SIGS-1:0] spiOut,
  input wire logic [`RT_SPI_SIGS-1:0] spiOe,
  input wire logic [`RT_TCA_OUTS-1:0] tcaOut,
  input wire logic [`RT_TCA_OUTS-1:0] tcaEn,
  input wire logic [`RT_TCB_OUTS-1:0] tcbOut,
  input wire logic [`RT_TCB_OUTS-1:0] tcbEn,
  output logic [`RT_PINS-1:0] ovrMask,
  output logic [`RT_PINS-1:0] ovrVal,
  output logic [`RT_PINS-1:0] ovrOe
);
  // Fixed default and alternate pin of each type-B timer output
  function automatic route_pkg::pin_idx_t tcbPin(input int idx, input logic alt);
    route_pkg::pin_idx_t p;
    p = alt ? `RT_TYPE_B_TIMER0_ROUTE_ALT : `RT_TYPE_B_TIMER0_ROUTE_DEF;
    unique case (idx)
      1: p = alt ? `RT_TYPE_B_TIMER1_ROUTE_ALT : `RT_TYPE_B_TIMER1_ROUTE_DEF;
      2: p = alt ? `RT_TYPE_B_TIMER2_ROUTE_ALT : `RT_TYPE_B_TIMER2_ROUTE_DEF;
      3: p = alt ? `RT_TYPE_B_TIMER3_ROUTE_ALT : `RT_TYPE_B_TIMER3_ROUTE_DEF;
      default: p = alt ? `RT_TYPE_B_TIMER0_ROUTE_ALT : `RT_TYPE_B_TIMER0_ROUTE_DEF;
    endcase
    return p;
  endfunction

  // Pin number within the flat vector, eight pins to a group
  function automatic route_pkg::pin_idx_t groupPin(input logic [2:0] g, input int b);
    return {g, 3'(b)};
  endfunction

  // Later claims win: SPI over type-A over type-B, so a clash never drives twice
  always_comb
  begin
    route_pkg::pin_idx_t p;
    route_pkg::pin_idx_t base;
    p = '0;
    base = '0;
    ovrMask = '0;
    ovrVal = '0;
    ovrOe = '0;
    // RULE4 RULE5 RULE6 RULE7: type-B pin choice
    for (int i = 0; i < `RT_TCB_OUTS; i++)
    begin
      if (tcbEn[i])
      begin
        p = tcbPin(i, cfg.tcbRoute[i]);
        ovrMask[p] = 1'b1;
        ovrVal[p] = tcbOut[i];
        ovrOe[p] = 1'b1;
      end
    end
    // RULE3: type-A outputs on pins 5..0, reserved codes claim nothing
    if (cfg.tcaRoute <= `RT_TCA_LAST)
    begin
      for (int b = 0; b < `RT_TCA_OUTS; b++)
      begin
        if (tcaEn[b])
        begin
          p = groupPin(cfg.tcaRoute, b);
          ovrMask[p] = 1'b1;
          ovrVal[p] = tcaOut[b];
          ovrOe[p] = 1'b1;
        end
      end
    end
    // RULE1: SPI on the chosen group, or detached
    if (cfg.spiRoute != route_pkg::SPI_DETACHED)
    begin
      unique case (cfg.spiRoute)
        route_pkg::SPI_ON_A_HIGH: base = `RT_PIN_A4;
        route_pkg::SPI_ON_C_LOW: base = `RT_PIN_C0;
        route_pkg::SPI_ON_E_LOW: base = `RT_PIN_E0;
        default: base = `RT_PIN_E0;
      endcase
      for (int s = 0; s < `RT_SPI_SIGS; s++)
      begin
        p = base + 6'(s);
        ovrMask[p] = 1'b1;
        ovrVal[p] = spiOut[s];
        ovrOe[p] = spiOe[s];
      end
    end
  end
endmodule

// ===== rtl/timer_spi_pin_route_select.sv
// Peripheral pin route selector: AXI4-Lite route registers and pin override
// Behaviour
// RULE1: SPI field 0x2 uses E3..0, 0x3 none
// RULE2: Type-A route field bits 2:0, resets zero
// RULE3: Type-A codes 0..5 pick groups A..F
// RULE4: Bit 3 moves timer B3 B5->C1
// RULE5: Bit 2 moves timer B2 C0->B4
// RULE6: Bit 1 moves timer B1 A3->F5
// RULE7: Bit 0 moves timer B0 A2->F4
// RULE8: Unselected pins return to general-purpose control
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "route_params.svh"
module timer_spi_pin_route_select #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [`RT_SPI_SIGS-1:0] spiOut,
  input wire logic [`RT_SPI_SIGS-1:0] spiOe,
  input wire logic [`RT_TCA_OUTS-1:0] typeATimerOut,
  input wire logic [`RT_TCA_OUTS-1:0] typeATimerEn,
  input wire logic [`RT_TCB_OUTS-1:0] typeBTimerOut,
  input wire logic [`RT_TCB_OUTS-1:0] typeBTimerEn,
  input wire logic [`RT_PINS-1:0] gpioOut,
  input wire logic [`RT_PINS-1:0] gpioOe,
  output logic [`RT_PINS-1:0] pinOut,
  output logic [`RT_PINS-1:0] pinOe,
  output logic [`RT_PINS-1:0] overrideMask
);
  // The highest register index must fit the word address
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [7:0] wData_r;
  logic wStrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  route_pkg::spi_route_t spiRoute_r;
  route_pkg::tca_route_t tcaRoute_r;
  route_pkg::tcb_route_t tcbRoute_r;
  logic [`RT_PINS-1:0] pinOut_r;
  logic [`RT_PINS-1:0] pinOe_r;
  logic [`RT_PINS-1:0] overrideMask_r;
  logic [`RT_PINS-1:0] ovrMask;
  logic [`RT_PINS-1:0] ovrVal;
  logic [`RT_PINS-1:0] ovrOe;
  logic doWrite;
  route_pkg::reg_sel_t wrSel;

  // Word index decode, shared by both channels; byte offsets are ignored
  function automatic route_pkg::reg_sel_t decodeReg(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(`RT_SPI_IDX))
      return route_pkg::REG_SPI;
    else if (idx == (ADDR_W-2)'(`RT_TCA_IDX))
      return route_pkg::REG_TCA;
    else if (idx == (ADDR_W-2)'(`RT_TCB_IDX))
      return route_pkg::REG_TCB;
    return route_pkg::REG_NONE;
  endfunction

  // Each channel is refused while its item waits or a response is pending
  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign doWrite = awHeld_r && wHeld_r;
  assign wrSel = decodeReg(awAddr_r);

  // Write address capture, in either order relative to the data
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end
    else if (awvalid && awready)
    begin
      awHeld_r <= 1'b1;
      awAddr_r <= awaddr;
    end
    else if (doWrite)
      awHeld_r <= 1'b0;
  end

  // Write data capture; only the low byte lane carries register bits
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wHeld_r <= 1'b0;
      wData_r <= 8'h00;
      wStrb0_r <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wHeld_r <= 1'b1;
      wData_r <= wdata[7:0];
      wStrb0_r <= wstrb[0];
    end
    else if (doWrite)
      wHeld_r <= 1'b0;
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `RT_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= (wrSel == route_pkg::REG_NONE) ? `RT_RESP_SLVERR : `RT_RESP_OKAY;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  // Route registers; upper bits are not stored and read as zero
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      spiRoute_r <= route_pkg::spi_route_t'(`RT_SPI_RESET);
      // RULE2 RULE7: reset to default routes
      tcaRoute_r <= `RT_TCA_RESET;
      tcbRoute_r <= `RT_TCB_RESET;
    end
    else if (doWrite && wStrb0_r)
    begin
      unique case (wrSel)
        route_pkg::REG_SPI: spiRoute_r <= route_pkg::spi_route_t'(wData_r[1:0]);
        // RULE2: three-bit type-A field
        route_pkg::REG_TCA: tcaRoute_r <= wData_r[2:0];
        // RULE7: four type-B select bits
        route_pkg::REG_TCB: tcbRoute_r <= wData_r[3:0];
        route_pkg::REG_NONE: ;
      endcase
    end
  end

  // Read channel; an unmapped word reads zero with a slave error
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= `RT_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= `RT_RESP_OKAY;
      unique case (decodeReg(araddr))
        route_pkg::REG_SPI: rdata_r <= 32'(spiRoute_r);
        route_pkg::REG_TCA: rdata_r <= 32'(tcaRoute_r);
        route_pkg::REG_TCB: rdata_r <= 32'(tcbRoute_r);
        route_pkg::REG_NONE:
        begin
          rdata_r <= 32'h00000000;
          rresp_r <= `RT_RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  route_cfg_if cfg ();
  assign cfg.spiRoute = spiRoute_r;
  assign cfg.tcaRoute = tcaRoute_r;
  assign cfg.tcbRoute = tcbRoute_r;

  route_mux u_mux (
    .cfg(cfg.sink),
    .spiOut(spiOut),
    .spiOe(spiOe),
    .tcaOut(typeATimerOut),
    .tcaEn(typeATimerEn),
    .tcbOut(typeBTimerOut),
    .tcbEn(typeBTimerEn),
    .ovrMask(ovrMask),
    .ovrVal(ovrVal),
    .ovrOe(ovrOe)
  );

  // RULE8: pins not claimed fall back to general-purpose drive
  // Registered so the pads never see decode glitches, at one cycle of latency
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pinOut_r <= '0;
      pinOe_r <= '0;
      overrideMask_r <= '0;
    end
    else
    begin
      pinOut_r <= (ovrMask & ovrVal) | (~ovrMask & gpioOut);
      pinOe_r <= (ovrMask & ovrOe) | (~ovrMask & gpioOe);
      overrideMask_r <= ovrMask;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign overrideMask = overrideMask_r;

  logic quietTimers;
  assign quietTimers = (typeBTimerEn == '0) && (tcaRoute_r > `RT_TCA_LAST);

  a_spi_on_e: assert property ( // RULE1
    (spiRoute_r == route_pkg::SPI_ON_E_LOW) |=>
      (pinOut_r[`RT_PIN_E0 +: `RT_SPI_SIGS] == $past(spiOut)) &&
      (pinOe_r[`RT_PIN_E0 +: `RT_SPI_SIGS] == $past(spiOe)) &&
      (overrideMask_r[`RT_PIN_E0 +: `RT_SPI_SIGS] == 4'hF))
    else $error("SPI not on group E pins 3..0");

  a_spi_detached: assert property ( // RULE1
    (spiRoute_r == route_pkg::SPI_DETACHED) && quietTimers |=> (overrideMask_r == '0))
    else $error("Detached SPI or reserved code still claims pins");

  a_route_reset: assert property ( // RULE2
    $rose(resetn) |-> (tcaRoute_r == `RT_TCA_RESET) && (tcbRoute_r == `RT_TCB_RESET))
    else $error("Route registers not at reset value");

  a_tca_readback: assert property ( // RULE2
    arvalid && arready && (decodeReg(araddr) == route_pkg::REG_TCA) |=>
      rvalid && (rdata == 32'($past(tcaRoute_r))) && (rresp == `RT_RESP_OKAY))
    else $error("Type-A route readback wrong");

  a_tca_group: assert property ( // RULE3
    (spiRoute_r == route_pkg::SPI_DETACHED) && (typeBTimerEn == '0) &&
      (tcaRoute_r <= `RT_TCA_LAST) && (typeATimerEn == 6'h3F) |=>
      (overrideMask_r == (`RT_TCA_MASK << {$past(tcaRoute_r), 3'h0})) &&
      (((pinOut_r >> {$past(tcaRoute_r), 3'h0}) & `RT_TCA_MASK) ==
        48'($past(typeATimerOut))))
    else $error("Type-A outputs on wrong group");

  a_type_b_timer3_route_pin: assert property ( // RULE4
    typeBTimerEn[3] && (spiRoute_r == route_pkg::SPI_DETACHED) &&
      (tcaRoute_r > `RT_TCA_LAST) |=>
      overrideMask_r[$past(tcbRoute_r[3]) ? `RT_TYPE_B_TIMER3_ROUTE_ALT : `RT_TYPE_B_TIMER3_ROUTE_DEF] &&
      (pinOut_r[$past(tcbRoute_r[3]) ? `RT_TYPE_B_TIMER3_ROUTE_ALT : `RT_TYPE_B_TIMER3_ROUTE_DEF] == $past(typeBTimerOut[3])))
    else $error("Timer B3 on wrong pin");

  a_type_b_timer2_route_pin: assert property ( // RULE5
    typeBTimerEn[2] && (spiRoute_r == route_pkg::SPI_DETACHED) &&
      (tcaRoute_r > `RT_TCA_LAST) |=>
      overrideMask_r[$past(tcbRoute_r[2]) ? `RT_TYPE_B_TIMER2_ROUTE_ALT : `RT_TYPE_B_TIMER2_ROUTE_DEF] &&
      (pinOut_r[$past(tcbRoute_r[2]) ? `RT_TYPE_B_TIMER2_ROUTE_ALT : `RT_TYPE_B_TIMER2_ROUTE_DEF] == $past(typeBTimerOut[2])))
    else $error("Timer B2 on wrong pin");

  a_type_b_timer1_route_pin: assert property ( // RULE6
    typeBTimerEn[1] && (spiRoute_r == route_pkg::SPI_DETACHED) &&
      (tcaRoute_r > `RT_TCA_LAST) |=>
      overrideMask_r[$past(tcbRoute_r[1]) ? `RT_TYPE_B_TIMER1_ROUTE_ALT : `RT_TYPE_B_TIMER1_ROUTE_DEF] &&
      (pinOut_r[$past(tcbRoute_r[1]) ? `RT_TYPE_B_TIMER1_ROUTE_ALT : `RT_TYPE_B_TIMER1_ROUTE_DEF] == $past(typeBTimerOut[1])))
    else $error("Timer B1 on wrong pin");

  a_type_b_timer0_route_pin: assert property ( // RULE7
    typeBTimerEn[0] && (spiRoute_r == route_pkg::SPI_DETACHED) &&
      (tcaRoute_r > `RT_TCA_LAST) |=>
      overrideMask_r[$past(tcbRoute_r[0]) ? `RT_TYPE_B_TIMER0_ROUTE_ALT : `RT_TYPE_B_TIMER0_ROUTE_DEF] &&
      (pinOut_r[$past(tcbRoute_r[0]) ? `RT_TYPE_B_TIMER0_ROUTE_ALT : `RT_TYPE_B_TIMER0_ROUTE_DEF] == $past(typeBTimerOut[0])))
    else $error("Timer B0 on wrong pin");

  a_gpio_release: assert property ( // RULE8
    (spiRoute_r == route_pkg::SPI_DETACHED) && (typeATimerEn == '0) && (typeBTimerEn == '0) |=>
      (pinOut_r == $past(gpioOut)) && (pinOe_r == $past(gpioOe)) && (overrideMask_r == '0))
    else $error("Released pins not under general-purpose control");

  // Unmapped words answer with a slave error, mapped ones with okay
  a_write_answer: assert property (
    doWrite |=> bvalid &&
      (bresp == (($past(wrSel) == route_pkg::REG_NONE) ? `RT_RESP_SLVERR : `RT_RESP_OKAY)))
    else $error("Write response missing or wrong");

  c_spi_on_e: cover property (spiRoute_r == route_pkg::SPI_ON_E_LOW);
  c_tca_group_f: cover property ((tcaRoute_r == `RT_TCA_LAST) && (typeATimerEn != '0));
  c_tcb_all_alt: cover property ((tcbRoute_r == 4'hF) && (typeBTimerEn == 4'hF));
  c_write_done: cover property (bvalid && bready && (bresp == `RT_RESP_OKAY));
endmodule

// ===== sim/periph_model.sv
// Peripheral-side stand-in: timer, serial and general-purpose drive patterns
`timescale 1ns/1ps
`include "route_params.svh"
module periph_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`RT_TCA_OUTS-1:0] aEnReq,
  input wire logic [`RT_TCB_OUTS-1:0] bEnReq,
  output logic [`RT_SPI_SIGS-1:0] spiOut,
  output logic [`RT_SPI_SIGS-1:0] spiOe,
  output logic [`RT_TCA_OUTS-1:0] typeATimerOut,
  output logic [`RT_TCA_OUTS-1:0] typeATimerEn,
  output logic [`RT_TCB_OUTS-1:0] typeBTimerOut,
  output logic [`RT_TCB_OUTS-1:0] typeBTimerEn,
  output logic [`RT_PINS-1:0] gpioOut,
  output logic [`RT_PINS-1:0] gpioOe
);
  logic [5:0] cnt_r;
  // Free-running pattern so a value one cycle stale never matches by luck, except on the spiOe pins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= 6'h00;
    else
      cnt_r <= cnt_r + 6'h01;
  end
  // Every source but spiOe changes each cycle, spiOe every second cycle; enables come from the bench
  assign spiOut = cnt_r[3:0];
  assign spiOe = ~cnt_r[4:1];
  assign typeATimerOut = cnt_r ^ 6'h2A;
  assign typeATimerEn = aEnReq;
  assign typeBTimerOut = ~cnt_r[3:0];
  assign typeBTimerEn = bEnReq;
  assign gpioOut = {8{cnt_r}};
  assign gpioOe = {8{~cnt_r}};
endmodule

// ===== sim/timer_spi_pin_route_select_tb_top.sv
// Bench for the peripheral pin route selector over AXI4-Lite
`timescale 1ns/1ps
`include "route_params.svh"
module timer_spi_pin_route_select_tb_top;
  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] spiOut, spiOe, tbOut, tbEn, bEn;
  logic [5:0] taOut, taEn, aEn, aPrev;
  logic [47:0] gOut, gOe, pinOut, pinOe, overrideMask, gPrev, gOePrev, m;
  logic [3:0] spiPrev, spiOePrev, wstrb;
  int n_mismatch, n_compared, k;
  int defPin[4] = '{2, 3, 16, 13};
  int altPin[4] = '{44, 45, 12, 17};
  logic [3:0] bCodes[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};

  timer_spi_pin_route_select #(.ADDR_W(8)) uut (.clock(clock), .resetn(resetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .spiOut(spiOut),
    .spiOe(spiOe), .typeATimerOut(taOut), .typeATimerEn(taEn), .typeBTimerOut(tbOut),
    .typeBTimerEn(tbEn), .gpioOut(gOut), .gpioOe(gOe), .pinOut(pinOut), .pinOe(pinOe),
    .overrideMask(overrideMask));
  periph_model model (.clock(clock), .resetn(resetn), .aEnReq(aEn), .bEnReq(bEn),
    .spiOut(spiOut), .spiOe(spiOe), .typeATimerOut(taOut), .typeATimerEn(taEn),
    .typeBTimerOut(tbOut), .typeBTimerEn(tbEn), .gpioOut(gOut), .gpioOe(gOe));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Inputs as the design registered them at the last edge
  always @(posedge clock)
  begin
    gPrev <= gOut;
    gOePrev <= gOe;
    aPrev <= taOut;
    spiPrev <= spiOut;
    spiOePrev <= spiOe;
  end

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Write: both items offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic aw, w, b;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clock);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b)
      begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ar, v;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clock);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
      if (v)
      begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // Pins owned by the current routes, from the route tables
  function automatic logic [47:0] expMask(input logic [1:0] s, input logic [2:0] a,
    input logic [3:0] b);
    logic [47:0] e;
    int i;
    e = '0;
    if (s == 2'h0) e[7:4] = 4'hF;
    if (s == 2'h1) e[19:16] = 4'hF;
    if (s == 2'h2) e[35:32] = 4'hF;
    // Union with the serial pins: group A shares bits 5..4 with them
    if (a <= 3'h5) e[a*8 +: 6] = e[a*8 +: 6] | aEn;
    for (i = 0; i < 4; i++)
      if (bEn[i]) e[b[i] ? altPin[i] : defPin[i]] = 1'b1;
    return e;
  endfunction

  // Let the write land, then compare ownership and pass-through
  task automatic checkPins(input logic [1:0] s, input logic [2:0] a, input logic [3:0] b);
    repeat (3) @(posedge clock);
    @(negedge clock);
    m = expMask(s, a, b);
    check("overrideMask", overrideMask, m);
    check("gpio pass", pinOut & ~m, gPrev & ~m);
    check("gpio oe pass", pinOe & ~m, gOePrev & ~m);
  endtask

  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    aEn = 6'h00;
    bEn = 4'h0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    // Reset values, unmapped places
    for (k = 3; k < 6; k++)
    begin
      axiRead(8'(k * 4), rd, rsp);
      check("reset value", 48'(rd), 48'h0);
    end
    axiRead(8'h18, rd, rsp);
    check("unmapped rresp", 48'(rsp), 48'h2);
    axiWrite(8'h18, 32'h000000FF, rsp);
    check("unmapped bresp", 48'(rsp), 48'h2);
    checkPins(2'h0, 3'h0, 4'h0);
    $display("Test reset done");
    // Serial route to group E, then to no pins
    axiWrite(`RT_SPI_IDX << 2, 32'h00000002, rsp);
    checkPins(2'h2, 3'h0, 4'h0);
    check("spi on E", 48'(pinOut[35:32]), 48'(spiPrev));
    check("spi oe on E", 48'(pinOe[35:32]), 48'(spiOePrev));
    axiWrite(`RT_SPI_IDX << 2, 32'h00000003, rsp);
    checkPins(2'h3, 3'h0, 4'h0);
    $display("Test serial done");
    // Every type-A code, reserved ones claim nothing
    aEn <= 6'h3F;
    for (k = 0; k < 8; k++)
    begin
      axiWrite(`RT_TCA_IDX << 2, 32'(k) | 32'hF8, rsp);
      axiRead(`RT_TCA_IDX << 2, rd, rsp);
      check("type A field", 48'(rd), 48'(k));
      checkPins(2'h3, 3'(k), 4'h0);
      if (k <= 5)
      begin
        check("type A value", 48'(pinOut[k*8 +: 6]), 48'(aPrev));
        check("type A oe", 48'(pinOe[k*8 +: 6]), 48'h3F);
      end
    end
    $display("Test type A done");
    // Each type-B select bit alone, all, then back to defaults
    aEn <= 6'h00;
    bEn <= 4'hF;
    for (k = 0; k < 6; k++)
    begin
      axiWrite(`RT_TCB_IDX << 2, 32'(bCodes[k]) | 32'hF0, rsp);
      axiRead(`RT_TCB_IDX << 2, rd, rsp);
      check("type B field", 48'(rd), 48'(bCodes[k]));
      checkPins(2'h3, 3'h7, bCodes[k]);
    end
    // Lane 0 strobe off: answered with okay, but the field keeps its value
    @(posedge clock);
    wstrb <= 4'h0;
    axiWrite(`RT_TCB_IDX << 2, 32'h0000000F, rsp);
    wstrb <= 4'hF;
    check("masked bresp", 48'(rsp), 48'h0);
    axiRead(`RT_TCB_IDX << 2, rd, rsp);
    check("masked write", 48'(rd), 48'h0);
    checkPins(2'h3, 3'h7, 4'h0);
    $display("Test type B done");
    stop_test();
  end
endmodule
